// >>> include/dct_pkg.sv
// Package with DDR2 command timing constants and types for the host controller
package dct_pkg;
    localparam int unsigned CLK_PERIOD_PS    = 100000;
    localparam int unsigned T_REFI_NORM_NS   = 7800;
    localparam int unsigned T_REFI_HOT_NS    = 3900;
    localparam int unsigned T_RFC_NS         = 75;
    localparam int unsigned T_RP_NS          = 15;
    localparam int unsigned T_RRD_1K_PS      = 7500;
    localparam int unsigned T_RRD_2K_PS      = 10000;
    localparam int unsigned T_RTP_PS         = 7500;
    localparam int unsigned T_WR_NS          = 15;
    localparam int unsigned T_WTR_533_PS     = 7500;
    localparam int unsigned T_WTR_400_PS     = 10000;
    localparam int unsigned T_XSNR_EXTRA_NS  = 10;
    localparam int unsigned PALL_EXTRA_CK    = 1;
    localparam int unsigned WTR_MIN_CK       = 2;
    localparam int unsigned XARD_CK          = 2;
    localparam int unsigned XARDS_BASE_CK    = 6;
    localparam int unsigned XP_CK            = 2;
    localparam int unsigned XSRD_CK          = 200;
    localparam int unsigned CCD_CK           = 2;
    localparam int unsigned CKE_MIN_CK       = 3;
    localparam int unsigned MRD_CK           = 2;
    localparam int unsigned MAX_POSTED       = 8;
    function automatic int unsigned ceil_ck(input int unsigned ps);
        int unsigned c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    function automatic int unsigned floor_ck(input int unsigned ps);
        int unsigned c;
        c = ps / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int unsigned REFI_NORM_CK = floor_ck(T_REFI_NORM_NS * 1000);
    localparam int unsigned REFI_HOT_CK  = floor_ck(T_REFI_HOT_NS * 1000);
    localparam int unsigned RFC_CK       = ceil_ck(T_RFC_NS * 1000);
    localparam int unsigned RP_CK        = ceil_ck(T_RP_NS * 1000);
    localparam int unsigned RRD_1K_CK    = ceil_ck(T_RRD_1K_PS);
    localparam int unsigned RRD_2K_CK    = ceil_ck(T_RRD_2K_PS);
    localparam int unsigned RTP_CK       = ceil_ck(T_RTP_PS);
    localparam int unsigned WR_CK        = ceil_ck(T_WR_NS * 1000);
    localparam int unsigned WTR_533_CK   = ceil_ck(T_WTR_533_PS);
    localparam int unsigned WTR_400_CK   = ceil_ck(T_WTR_400_PS);
    localparam int unsigned XSNR_CK      = ceil_ck((T_RFC_NS + T_XSNR_EXTRA_NS) * 1000);
    localparam int unsigned MR_PD_BIT    = 12;
    localparam int unsigned MR_WR_LSB    = 9;
    localparam int unsigned CNT_W        = 8;
    localparam int unsigned POST_W       = 4;
    // Command codes on {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_RD    = 4'h5;
    localparam logic [3:0] CMD_WR    = 4'h4;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_MRS   = 4'h0;
    localparam logic [3:0] CMD_DESEL = 4'h8;
    typedef enum logic [2:0]
    {
        REQ_NONE, REQ_ACT, REQ_RD, REQ_WR, REQ_PRE, REQ_PALL, REQ_MRS
    } dct_req_type;
endpackage

// >>> rtl/dct_down_counter.sv
// Loadable down counter that tells when a spacing has elapsed
`timescale 1ns/1ns
`default_nettype none
module dct_down_counter
    import dct_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    output var  logic             done
);
    logic [CNT_W-1:0] count_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            count_reg <= '0;
        else if (ce)
        begin
            // A load counts the issue cycle itself, so load one less
            if (load)
                count_reg <= (load_val == '0) ? '0 : load_val - 1'b1;
            else if (count_reg != '0)
                count_reg <= count_reg - 1'b1;
        end
    end
    assign done = (count_reg == '0);
endmodule
`default_nettype wire

// >>> rtl/dct_host_ctrl.sv
// DDR2 host command sequencer that enforces command spacing
`timescale 1ns/1ns
`default_nettype none
module dct_host_ctrl
    import dct_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        hot_mode,
    input  wire logic        grade_533,
    input  wire logic        page_2k,
    input  wire logic [2:0]  additive_latency,
    input  wire dct_req_type req_kind,
    input  wire logic [1:0]  req_bank,
    input  wire logic [13:0] req_addr,
    input  wire logic        req_auto_pre,
    input  wire logic        req_pd,
    input  wire logic        req_sr,
    input  wire logic        init_done,
    output logic             req_ready,
    output logic             freq_change_ok,
    output logic             reinit_needed,
    output logic             mem_cke,
    output logic [3:0]       mem_cmd,
    output logic [1:0]       mem_ba,
    output logic [13:0]      mem_addr
);
    typedef enum logic [2:0]
    {
        ST_RUN, ST_PD_ACT, ST_PD_PRE, ST_SELF, ST_EXIT
    } dct_state_type;

    dct_state_type state_reg;
    dct_state_type exit_from_reg;
    logic [CNT_W-1:0]  refi_reg;
    logic [POST_W-1:0] posted_reg;
    logic [3:0]        open_reg;
    logic [3:0]        cmd_next;
    logic [1:0]        cke_hold_reg;
    logic              slow_exit_reg;
    logic [3:0]        wr_field_reg;
    logic [CNT_W-1:0]  exit_rd_reg;
    logic [CNT_W-1:0]  exit_any_reg;
    logic              do_act;
    logic              do_rd;
    logic              do_wr;
    logic              do_pre;
    logic              do_pall;
    logic              do_mrs;
    logic              do_ref;
    logic              cmd_ok;
    logic              ld_any;
    logic [CNT_W-1:0]  v_any;
    logic              ok_any;
    logic              ok_act;
    logic              ok_col;
    logic              ok_rd;
    logic              ok_ref;
    logic [3:0]        ok_bank_act;
    logic [3:0]        ok_bank_pre;
    logic              cke_free;
    logic              lp_go;

    function automatic logic [CNT_W-1:0] to_cnt(input int unsigned v);
        return v[CNT_W-1:0];
    endfunction

    // Global spacing: MRS, precharge-all and refresh
    always_comb
    begin
        ld_any = 1'b1;
        v_any  = '0;
        if (do_ref)
            v_any = to_cnt(RFC_CK);
        else if (do_pall)
            v_any = to_cnt(RP_CK + PALL_EXTRA_CK);
        else if (do_mrs)
            v_any = to_cnt(MRD_CK);
        else
            ld_any = 1'b0;
    end

    dct_down_counter u_any
    (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (clk_en),
        .load     (ld_any),
        .load_val (v_any),
        .done     (ok_any)
    );

    dct_down_counter u_act
    (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (clk_en),
        .load     (do_act),
        .load_val (to_cnt(page_2k ? RRD_2K_CK : RRD_1K_CK)),
        .done     (ok_act)
    );

    dct_down_counter u_col
    (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (clk_en),
        .load     (do_rd | do_wr),
        .load_val (to_cnt(CCD_CK)),
        .done     (ok_col)
    );

    // Write to read turnaround; the two-clock floor is above every grade figure here
    dct_down_counter u_wtr
    (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (clk_en),
        .load     (do_wr),
        .load_val (to_cnt((grade_533 ? WTR_533_CK : WTR_400_CK) < WTR_MIN_CK ?
                          WTR_MIN_CK : (grade_533 ? WTR_533_CK : WTR_400_CK))),
        .done     (ok_rd)
    );

    dct_down_counter u_ref
    (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (clk_en),
        .load     (do_ref),
        .load_val (to_cnt(RFC_CK)),
        .done     (ok_ref)
    );

    // Per-bank precharge and activate windows
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_bank
            logic ld_pre;
            logic ld_act;
            logic [CNT_W-1:0] v_pre;
            logic [CNT_W-1:0] v_act;
            always_comb
            begin
                ld_pre = (do_rd | do_wr) && req_bank == b[1:0];
                v_pre  = do_wr ? to_cnt(CCD_CK + WR_CK) : to_cnt(RTP_CK);
                ld_act = (do_pre && req_bank == b[1:0]) || do_pall
                         || (do_wr && req_auto_pre && req_bank == b[1:0]);
                v_act  = (do_wr && req_auto_pre) ?
                         to_cnt(CCD_CK) + {4'h0, wr_field_reg} + to_cnt(RP_CK) :
                         to_cnt(RP_CK);
            end
            dct_down_counter u_pre
            (
                .core_clk (core_clk),
                .rst      (rst),
                .ce       (clk_en),
                .load     (ld_pre),
                .load_val (v_pre),
                .done     (ok_bank_pre[b])
            );
            dct_down_counter u_bact
            (
                .core_clk (core_clk),
                .rst      (rst),
                .ce       (clk_en),
                .load     (ld_act),
                .load_val (v_act),
                .done     (ok_bank_act[b])
            );
        end
    endgenerate

    // Command decision
    always_comb
    begin
        // No issue while ready stands: the requester drops only at the next edge
        cmd_ok  = state_reg == ST_RUN && ok_any && !reinit_needed && !req_ready;
        do_ref  = cmd_ok && posted_reg != '0 && ok_ref && open_reg == '0;
        do_act  = cmd_ok && !do_ref && req_kind == REQ_ACT && ok_act && ok_ref
                  && ok_bank_act[req_bank] && posted_reg < POST_W'(MAX_POSTED);
        do_rd   = cmd_ok && !do_ref && req_kind == REQ_RD && ok_col && ok_rd
                  && exit_rd_reg == '0;
        do_wr   = cmd_ok && !do_ref && req_kind == REQ_WR && ok_col;
        do_pre  = cmd_ok && !do_ref && req_kind == REQ_PRE && ok_bank_pre[req_bank];
        do_pall = cmd_ok && !do_ref && req_kind == REQ_PALL && (&ok_bank_pre);
        do_mrs  = cmd_ok && !do_ref && req_kind == REQ_MRS && open_reg == '0;
        // Refresh with clock enable falling would enter self-refresh
        lp_go   = state_reg == ST_RUN && cke_free && ok_any && ok_ref && !do_ref
                  && req_kind == REQ_NONE && (req_sr || req_pd)
                  && posted_reg < POST_W'(MAX_POSTED);
        cmd_next = CMD_NOP;
        if (do_ref)
            cmd_next = CMD_REF;
        else if (do_act)
            cmd_next = CMD_ACT;
        else if (do_rd)
            cmd_next = CMD_RD;
        else if (do_wr)
            cmd_next = CMD_WR;
        else if (do_pre || do_pall)
            cmd_next = CMD_PRE;
        else if (do_mrs)
            cmd_next = CMD_MRS;
        else if (lp_go && req_sr && open_reg == '0)
            cmd_next = CMD_REF;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mem_cmd  <= CMD_DESEL;
            mem_ba   <= '0;
            mem_addr <= '0;
        end
        else if (clk_en)
        begin
            mem_cmd  <= cmd_next;
            mem_ba   <= req_bank;
            mem_addr <= do_pall ? 14'h0400 : ((do_rd || do_wr) ?
                        {req_addr[13:11], req_auto_pre, req_addr[9:0]} : req_addr);
        end
    end

    // Open-bank tracking
    always_ff @(posedge core_clk)
    begin
        if (rst)
            open_reg <= '0;
        else if (clk_en)
        begin
            if (do_act)
                open_reg[req_bank] <= 1'b1;
            else if (do_pall)
                open_reg <= '0;
            else if (do_pre || ((do_rd || do_wr) && req_auto_pre))
                open_reg[req_bank] <= 1'b0;
        end
    end

    // Mode register shadow: exit style and write recovery field
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            slow_exit_reg <= 1'b0;
            wr_field_reg  <= 4'(WR_CK);
        end
        else if (clk_en && do_mrs && req_bank == 2'h0)
        begin
            slow_exit_reg <= req_addr[MR_PD_BIT];
            // Field never programmed below the recovery time in clocks
            wr_field_reg  <= ({1'b0, req_addr[MR_WR_LSB+:3]} + 4'h1 < 4'(WR_CK)) ?
                             4'(WR_CK) : {1'b0, req_addr[MR_WR_LSB+:3]} + 4'h1;
        end
    end

    // Refresh interval timer and posted count
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            refi_reg   <= '0;
            posted_reg <= '0;
        end
        else if (clk_en)
        begin
            if (state_reg == ST_SELF)
            begin
                refi_reg   <= '0;
                posted_reg <= '0;
            end
            else
            begin
                if (refi_reg + 1'b1 >= to_cnt(hot_mode ? REFI_HOT_CK : REFI_NORM_CK))
                    refi_reg <= '0;
                else
                    refi_reg <= refi_reg + 1'b1;
                // Due tick and issue in one cycle cancel out
                if (refi_reg + 1'b1 >= to_cnt(hot_mode ? REFI_HOT_CK : REFI_NORM_CK)
                    && !do_ref && posted_reg < POST_W'(MAX_POSTED))
                    posted_reg <= posted_reg + 1'b1;
                else if (do_ref && !(refi_reg + 1'b1 >=
                         to_cnt(hot_mode ? REFI_HOT_CK : REFI_NORM_CK)))
                    posted_reg <= posted_reg - 1'b1;
            end
        end
    end

    // Clock enable minimum pulse width
    assign cke_free = cke_hold_reg == '0;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg     <= ST_RUN;
            exit_from_reg <= ST_RUN;
            mem_cke       <= 1'b1;
            cke_hold_reg  <= '0;
            exit_any_reg  <= '0;
            exit_rd_reg   <= '0;
        end
        else if (clk_en)
        begin
            if (cke_hold_reg != '0)
                cke_hold_reg <= cke_hold_reg - 1'b1;
            if (exit_rd_reg != '0)
                exit_rd_reg <= exit_rd_reg - 1'b1;
            case (state_reg)
                ST_RUN:
                    if (lp_go)
                    begin
                        mem_cke      <= 1'b0;
                        cke_hold_reg <= 2'(CKE_MIN_CK - 1);
                        state_reg    <= req_sr && open_reg == '0 ? ST_SELF :
                                        (open_reg == '0 ? ST_PD_PRE : ST_PD_ACT);
                    end
                ST_PD_ACT, ST_PD_PRE, ST_SELF:
                    if (cke_free && !(req_sr || req_pd))
                    begin
                        mem_cke       <= 1'b1;
                        cke_hold_reg  <= 2'(CKE_MIN_CK - 1);
                        exit_from_reg <= state_reg;
                        state_reg     <= ST_EXIT;
                        if (state_reg == ST_SELF)
                        begin
                            exit_any_reg <= to_cnt(XSNR_CK - 1);
                            exit_rd_reg  <= to_cnt(XSRD_CK - 1);
                        end
                        else if (state_reg == ST_PD_PRE)
                            exit_any_reg <= to_cnt(XP_CK - 1);
                        else
                        begin
                            exit_any_reg <= to_cnt(XARD_CK - 1);
                            exit_rd_reg  <= slow_exit_reg ?
                                to_cnt(XARDS_BASE_CK - 1) - {5'h0, additive_latency} : '0;
                        end
                    end
                ST_EXIT:
                    if (exit_any_reg <= 8'h01)
                        state_reg <= ST_RUN;
                    else
                        exit_any_reg <= exit_any_reg - 1'b1;
                default:
                    state_reg <= ST_RUN;
            endcase
        end
    end

    // Ready, frequency window and re-initialisation flag
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            req_ready      <= 1'b0;
            freq_change_ok <= 1'b0;
            reinit_needed  <= 1'b0;
        end
        else if (clk_en)
        begin
            req_ready      <= do_act | do_rd | do_wr | do_pre | do_pall | do_mrs;
            freq_change_ok <= state_reg == ST_SELF || state_reg == ST_PD_PRE;
            // Posting overflow would break spacing; hold until re-initialised
            if (posted_reg == POST_W'(MAX_POSTED) && state_reg != ST_RUN
                && state_reg != ST_SELF)
                reinit_needed <= 1'b1;
            else if (init_done)
                reinit_needed <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/dct_ddr2_model.sv
// Behavioural DDR2 device that counts command spacing faults
`timescale 1ns/1ns
`default_nettype none
module dct_ddr2_model
    import dct_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [2:0]  additive_latency,
    input  wire logic        mem_cke,
    input  wire logic [3:0]  mem_cmd,
    input  wire logic [1:0]  mem_ba,
    input  wire logic [13:0] mem_addr,
    output var  logic [7:0]  viol_count,
    output var  logic [7:0]  ref_count,
    output var  logic        mode_slow = 1'b0
);
    localparam int WTR_CK = (WTR_400_CK > WTR_MIN_CK) ? WTR_400_CK : WTR_MIN_CK;
    int         cyc = 0;
    int         t_ref = -1000, t_act = -1000, t_rd = -1000, t_wr = -1000, t_col = -1000;
    int         t_mrs = -1000, t_pall = -1000, t_up = -1000;
    int         t_dal [4] = '{default: -1000};
    logic [2:0] mr_wr = 3'h0;
    logic [3:0] open_reg = 4'h0;
    logic       sr_reg = 1'b0, apd_reg = 1'b0, cke_q = 1'b1, v;
    wire logic  live = !mem_cmd[3] && (mem_cmd != CMD_NOP);
    wire logic  rd = (mem_cmd == CMD_RD);
    wire logic  wr = (mem_cmd == CMD_WR);
    wire logic  act = (mem_cmd == CMD_ACT);
    // Spacing measured from command edges, a little stricter than from data
    always_comb
    begin
        v = live && (cyc - t_mrs < MRD_CK);
        v = v || (live && cyc - t_pall < RP_CK + PALL_EXTRA_CK);
        v = v || (live && !sr_reg && cyc - t_up < XP_CK);
        v = v || (live && sr_reg && !rd && cyc - t_up < XSNR_CK);
        v = v || (rd && sr_reg && cyc - t_up < XSRD_CK);
        v = v || (rd && apd_reg && mode_slow && cyc - t_up < XARDS_BASE_CK - additive_latency);
        v = v || ((act || mem_cmd == CMD_REF) && cyc - t_ref < RFC_CK);
        v = v || (act && cyc - t_act < RRD_2K_CK);
        v = v || (act && cyc - t_dal[mem_ba] < mr_wr + 1 + RP_CK);
        v = v || (mem_cmd == CMD_PRE && (cyc - t_rd < RTP_CK || cyc - t_wr < WR_CK));
        v = v || (rd && cyc - t_wr < WTR_CK);
        v = v || ((rd || wr) && cyc - t_col < CCD_CK);
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        cke_q <= mem_cke;
        viol_count <= rst ? 8'h00 : viol_count + {7'h00, v};
        ref_count <= rst ? 8'h00 : ref_count + {7'h00, mem_cmd == CMD_REF && mem_cke};
        if (mem_cke && !cke_q) t_up <= cyc;
        if (!mem_cke && cke_q) sr_reg <= (mem_cmd == CMD_REF);
        if (!mem_cke && cke_q) apd_reg <= |open_reg;
        if (mem_cmd == CMD_MRS) t_mrs <= cyc;
        if (mem_cmd == CMD_MRS && mem_ba == 2'h0) mode_slow <= mem_addr[MR_PD_BIT];
        if (mem_cmd == CMD_MRS && mem_ba == 2'h0) mr_wr <= mem_addr[11:9];
        if (mem_cmd == CMD_REF) t_ref <= cyc;
        if (act) t_act <= cyc;
        if (act) open_reg[mem_ba] <= 1'b1;
        if (rd) t_rd <= cyc;
        if (wr) t_wr <= cyc;
        if (rd || wr) t_col <= cyc;
        if (wr && mem_addr[10]) t_dal[mem_ba] <= cyc;
        if ((rd || wr) && mem_addr[10]) open_reg[mem_ba] <= 1'b0;
        if (mem_cmd == CMD_PRE) open_reg <= mem_addr[10] ? 4'h0 : open_reg & ~(4'h1 << mem_ba);
        if (mem_cmd == CMD_PRE && mem_addr[10]) t_pall <= cyc;
    end
endmodule
`default_nettype wire

// >>> verif/dct_host_chk.sv
// Pin-level assertions for the DDR2 host command sequencer
`timescale 1ns/1ns
`default_nettype none
module dct_host_chk
    import dct_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        freq_change_ok,
    input wire logic        mem_cke,
    input wire logic [3:0]  mem_cmd,
    input wire logic [1:0]  mem_ba,
    input wire logic [13:0] mem_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic       col  = (mem_cmd == CMD_RD) || (mem_cmd == CMD_WR);
    wire logic       idle = mem_cmd[3] || (mem_cmd == CMD_NOP);
    logic            sr_reg;
    logic [7:0]      since_reg;
    // Self-refresh entry is a refresh issued in the cycle clock enable falls
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sr_reg <= 1'b0;
        else if (!mem_cke && $past(mem_cke))
            sr_reg <= (mem_cmd == CMD_REF);
    end
    always_ff @(posedge core_clk)
    begin
        if (rst || $rose(mem_cke))
            since_reg <= 8'h00;
        else if (since_reg != 8'hff)
            since_reg <= since_reg + 8'h01;
    end
    ccd_space_a: assert property (col |=> !col)
        else $error("column commands too close");
    mrd_space_a: assert property (mem_cmd == CMD_MRS |=> idle)
        else $error("command too soon after mode set");
    wtr_space_a: assert property (mem_cmd == CMD_WR |=> mem_cmd != CMD_RD)
        else $error("read too soon after write");
    pall_space_a: assert property (mem_cmd == CMD_PRE && mem_addr[10] |=> idle)
        else $error("command too soon after precharge all");
    dal_wait_a: assert property (mem_cmd == CMD_WR && mem_addr[10] |=>
        !(mem_cmd == CMD_ACT && mem_ba == $past(mem_ba))) else $error("activate inside write recovery");
    cke_hold_a: assert property ($changed(mem_cke) |=> $stable(mem_cke) [*2])
        else $error("clock enable pulse too short");
    pd_exit_a: assert property ($rose(mem_cke) |-> idle ##1 idle)
        else $error("command too soon after power-down exit");
    xsrd_wait_a: assert property (mem_cmd == CMD_RD && sr_reg |-> since_reg >= 8'hc7)
        else $error("read too soon after self-refresh exit");
    freq_ok_a: assert property (freq_change_ok |-> !mem_cke || !$past(mem_cke))
        else $error("frequency change allowed while clocked");
    cover property (mem_cmd == CMD_MRS && mem_addr[12]);
    cover property ($rose(mem_cke) && sr_reg);
    cover property (mem_cmd == CMD_PRE && mem_addr[10]);
endmodule
bind dct_host_ctrl dct_host_chk chk (.core_clk(core_clk), .rst(rst),
    .freq_change_ok(freq_change_ok), .mem_cke(mem_cke), .mem_cmd(mem_cmd),
    .mem_ba(mem_ba), .mem_addr(mem_addr));
`default_nettype wire

// >>> verif/dct_host_ctrl_bench.sv
// Self-checking bench for the DDR2 host command sequencer
`timescale 1ns/1ns
`default_nettype none
module dct_host_ctrl_bench
    import dct_pkg::*;
;
    logic             core_clk = 1'b0, rst = 1'b1, hot_mode = 1'b0, grade_533 = 1'b1;
    logic             page_2k = 1'b0, req_pd = 1'b0, req_sr = 1'b0, init_done = 1'b0;
    logic             req_auto_pre = 1'b0;
    logic [1:0]       req_bank = 2'h0;
    logic [13:0]      req_addr = 14'h0000;
    dct_req_type      req_kind = REQ_NONE;
    wire logic        req_ready, freq_change_ok, reinit_needed, mem_cke, mode_slow;
    wire logic [3:0]  mem_cmd;
    wire logic [1:0]  mem_ba;
    wire logic [13:0] mem_addr;
    wire logic [7:0]  viol_count, ref_count;
    int               num_errors = 0, cmp_count = 0;
    logic [7:0]       refs;
    always #50 core_clk = ~core_clk;
    dct_host_ctrl dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .hot_mode(hot_mode),
        .grade_533(grade_533), .page_2k(page_2k), .additive_latency(3'h2),
        .req_kind(req_kind), .req_bank(req_bank), .req_addr(req_addr),
        .req_auto_pre(req_auto_pre), .req_pd(req_pd), .req_sr(req_sr), .init_done(init_done),
        .req_ready(req_ready), .freq_change_ok(freq_change_ok), .reinit_needed(reinit_needed),
        .mem_cke(mem_cke), .mem_cmd(mem_cmd), .mem_ba(mem_ba), .mem_addr(mem_addr));
    dct_ddr2_model mdl (.core_clk(core_clk), .rst(rst), .additive_latency(3'h2),
        .mem_cke(mem_cke), .mem_cmd(mem_cmd), .mem_ba(mem_ba), .mem_addr(mem_addr),
        .viol_count(viol_count), .ref_count(ref_count), .mode_slow(mode_slow));
    task automatic final_report();
        $display("errors=%0d comparisons=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_vec(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_vec({13'h0000, got}, {13'h0000, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wait_edge(input int n);
        if (n > 700)
        begin
            num_errors++;
            final_report();
        end
        else
            @(posedge core_clk);
    endtask
    task automatic wait_cke(input logic lvl);
        int n;
        n = 0;
        while (mem_cke !== lvl)
            wait_edge(n++);
    endtask
    // Request held until the edge that samples ready high, dropped there
    task automatic issue(input dct_req_type k, input logic [1:0] b, input logic ap,
                         input logic [3:0] exp);
        int n;
        @(posedge core_clk);
        req_kind <= k;
        req_bank <= b;
        req_addr <= (k == REQ_MRS) ? 14'h1000 : 14'h0000;
        req_auto_pre <= ap;
        n = 0;
        wait_edge(n++);
        while (req_ready !== 1'b1)
            wait_edge(n++);
        req_kind <= REQ_NONE;
        chk_vec({10'h000, mem_cmd}, {10'h000, exp});
        chk_vec({12'h000, mem_ba}, {12'h000, b});
    endtask
    task automatic s_mode();
        issue(REQ_MRS, 2'h0, 1'b0, CMD_MRS);
        chk_vec(mem_addr, 14'h1000);
        issue(REQ_MRS, 2'h0, 1'b0, CMD_MRS);
        cyc(1);
        chk_bit(mode_slow, 1'b1);
    endtask
    task automatic s_refresh(input logic hot, input int per);
        @(posedge core_clk);
        hot_mode <= hot;
        cyc(1);
        refs = ref_count;
        cyc(1000);
        refs = ref_count - refs;
        chk_bit(refs inside {[1000 / per - 1 : 1000 / per + 2]}, 1'b1);
    endtask
    task automatic s_rw();
        page_2k <= 1'b1;
        issue(REQ_ACT, 2'h0, 1'b0, CMD_ACT);
        issue(REQ_ACT, 2'h1, 1'b0, CMD_ACT);
        issue(REQ_WR, 2'h0, 1'b0, CMD_WR);
        issue(REQ_RD, 2'h0, 1'b0, CMD_RD);
        issue(REQ_PRE, 2'h0, 1'b0, CMD_PRE);
        issue(REQ_WR, 2'h1, 1'b1, CMD_WR);
        chk_bit(mem_addr[10], 1'b1);
        issue(REQ_ACT, 2'h1, 1'b0, CMD_ACT);
        issue(REQ_ACT, 2'h2, 1'b0, CMD_ACT);
        issue(REQ_PALL, 2'h0, 1'b0, CMD_PRE);
        chk_bit(mem_addr[10], 1'b1);
        issue(REQ_ACT, 2'h2, 1'b0, CMD_ACT);
        page_2k <= 1'b0;
    endtask
    task automatic s_lowpower(input logic sr, input int hold, input logic frq);
        @(posedge core_clk);
        req_pd <= !sr;
        req_sr <= sr;
        wait_cke(1'b0);
        cyc(2);
        chk_bit(freq_change_ok, frq);
        cyc(hold);
        chk_bit(reinit_needed, hold > 8 * REFI_NORM_CK);
        refs = ref_count;
        @(posedge core_clk);
        req_pd <= 1'b0;
        req_sr <= 1'b0;
        wait_cke(1'b1);
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        s_mode();
        s_refresh(1'b0, REFI_NORM_CK);
        s_refresh(1'b1, REFI_HOT_CK);
        hot_mode <= 1'b0;
        s_rw();
        grade_533 <= 1'b0;
        s_lowpower(1'b0, 10, 1'b0);
        issue(REQ_RD, 2'h2, 1'b0, CMD_RD);
        issue(REQ_PALL, 2'h0, 1'b0, CMD_PRE);
        s_lowpower(1'b0, 8 * REFI_NORM_CK + 20, 1'b1);
        @(posedge core_clk);
        init_done <= 1'b1;
        @(posedge core_clk);
        init_done <= 1'b0;
        cyc(1);
        chk_bit(reinit_needed, 1'b0);
        issue(REQ_ACT, 2'h0, 1'b0, CMD_ACT);
        issue(REQ_PALL, 2'h0, 1'b0, CMD_PRE);
        cyc(40);
        refs = ref_count - refs;
        chk_bit(refs inside {[MAX_POSTED : MAX_POSTED + 1]}, 1'b1);
        s_lowpower(1'b1, 20, 1'b1);
        issue(REQ_ACT, 2'h1, 1'b0, CMD_ACT);
        issue(REQ_RD, 2'h1, 1'b0, CMD_RD);
        issue(REQ_PALL, 2'h0, 1'b0, CMD_PRE);
        chk_vec({6'h00, viol_count}, 14'h0000);
        final_report();
    end
endmodule
`default_nettype wire
